// *** verilog/fmf_pkg.sv ***
// Package for the flash mass-storage front end.
// Assumes a single 200 MHz pclk and APB register access.
package fmf_pkg;
   // Register byte offsets
   localparam logic [11:0] FMF_CTRL_OFS    = 12'h000;
   localparam logic [11:0] FMF_LUNCFG_OFS  = 12'h004;
   localparam logic [11:0] FMF_CMD_OFS     = 12'h008;
   localparam logic [11:0] FMF_STAT_OFS    = 12'h00C;
   localparam logic [11:0] FMF_PASS_OFS    = 12'h010;
   localparam logic [11:0] FMF_MAP_OFS     = 12'h014;
   localparam logic [11:0] FMF_RESULT_OFS  = 12'h018;
   localparam logic [11:0] FMF_SPEED_OFS   = 12'h01C;
   // CTRL fields
   localparam int FMF_CTRL_RDIV_LSB = 0;
   localparam int FMF_CTRL_WDIV_LSB = 4;
   localparam int FMF_CTRL_RED_LSB  = 8;
   localparam int FMF_CTRL_LED1_BIT = 10;
   // LUNCFG fields
   localparam int FMF_LUN_PRIV_BIT  = 0;
   localparam int FMF_LUN_ADD_BIT   = 1;
   localparam int FMF_LUN_PTYP_LSB  = 2;
   localparam int FMF_LUN_ATYP_LSB  = 4;
   localparam int FMF_LUN_CD2K_BIT  = 6;
   // CMD codes
   localparam logic [3:0] FMF_CMD_WRITE  = 4'h1;
   localparam logic [3:0] FMF_CMD_ERASE  = 4'h2;
   localparam logic [3:0] FMF_CMD_READ   = 4'h3;
   localparam logic [3:0] FMF_CMD_UNLOCK = 4'h4;
   localparam logic [3:0] FMF_CMD_LOCK   = 4'h5;
   localparam logic [3:0] FMF_CMD_LATE   = 4'h6;
   localparam logic [3:0] FMF_CMD_QUERY  = 4'h7;
   // Reset values
   localparam logic [31:0] FMF_CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] FMF_LUNCFG_RST = 32'h0000_0000;
   localparam logic [31:0] FMF_PASS_RST   = 32'h0000_0000;
   // Map sizes
   localparam int          FMF_ZONE_BLOCKS = 1024;
   localparam logic [10:0] FMF_USED_FULL   = 11'd1000;
   localparam logic [10:0] FMF_USED_90     = 11'd900;
   localparam logic [10:0] FMF_USED_50     = 11'd500;
   // Strobe rates in MHz and divider counts
   localparam int FMF_CLK_MHZ = 200;
   localparam int FMF_R30 = 30;
   localparam int FMF_R20 = 20;
   localparam int FMF_R15 = 15;
   localparam int FMF_R12 = 12;
   localparam int FMF_R10 = 10;
   localparam logic [4:0] FMF_DIV30 = 5'((FMF_CLK_MHZ + FMF_R30 - 1) / FMF_R30);
   localparam logic [4:0] FMF_DIV20 = 5'((FMF_CLK_MHZ + FMF_R20 - 1) / FMF_R20);
   localparam logic [4:0] FMF_DIV15 = 5'((FMF_CLK_MHZ + FMF_R15 - 1) / FMF_R15);
   localparam logic [4:0] FMF_DIV12 = 5'((FMF_CLK_MHZ + FMF_R12 - 1) / FMF_R12);
   localparam logic [4:0] FMF_DIV10 = 5'((FMF_CLK_MHZ + FMF_R10 - 1) / FMF_R10);
   localparam logic [7:0] FMF_LED_HOLD = 8'hFF;
   // Drive types
   typedef enum logic [1:0] {
      FMF_REMOVABLE, FMF_HARDDISK, FMF_OPTICAL
   } fmf_type_e;
   // Status codes
   localparam logic [1:0] FMF_ST_OK    = 2'h0;
   localparam logic [1:0] FMF_ST_WPROT = 2'h1;
   localparam logic [1:0] FMF_ST_NOLUN = 2'h2;
   localparam logic [1:0] FMF_ST_LOCK  = 2'h3;
endpackage : fmf_pkg

// *** verilog/fmf_map_ram.sv ***
// Single-port block map memory with registered read data.
// Assumes one clock; write and read in the same cycle return old data.
`timescale 1ns/1ps
`default_nettype none
module fmf_map_ram (
   input  wire logic        pclk,
   input  wire logic        we,
   input  wire logic [9:0]  addr,
   input  wire logic [9:0]  wdata,
   output var  logic [9:0]  rdata
);
   logic [9:0] mem [0:1023];

   always_ff @(posedge pclk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule : fmf_map_ram
`default_nettype wire

// *** verilog/fmf_front.sv ***
// Flash mass-storage front end: LUN decode, write protect, block map
// with LRU free list, flash strobe dividers and activity indicators.
// Assumes an APB master, a flash array and a USB PHY outside.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Replacement block is oldest free entry
// - Copy, write, erase, then update map
// - Read and write strobe rates independent
// - Reduction shrinks used part to 900/500
// - High/full speed, endpoints 0 and 2
// - Speed settles by bus negotiation
// - At most three drives presented
// - Public drive is LUN 0, typed
// - Private drive LUN 1, always removable
// - Private drive locked until password unlock
// - Additional drive LUN 1 or 2
// - Public optical drive 2K blocks on variant
// - Indicators follow flash and USB
// - Indicator one off: second shows both
// - Protect low and driven: all commands accepted
// - Protect high: modifying commands refused
// - Zones of 1024-entry used/free/bad map
// - Late bad block replaced from free part
module fmf_front (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic        write_protect,
   input  wire logic        wp_driven,
   input  wire logic        usb_high_speed,
   input  wire logic        usb_activity,
   output var  logic        flash_read_strobe,
   output var  logic        flash_write_strobe,
   output var  logic        flash_busy,
   output var  logic        flash_activity_indicator,
   output var  logic        usb_activity_indicator
);
   import fmf_pkg::*;

   typedef enum {
      FMF_IDLE, FMF_PICK, FMF_COPY, FMF_WRDATA, FMF_ERASE, FMF_UPD_USED,
      FMF_UPD_FREE, FMF_LATE
   } fmf_state_e;

   function automatic logic [4:0] fmf_div(input logic [2:0] sel);
      unique case (sel)
         3'd0:    fmf_div = FMF_DIV30;
         3'd1:    fmf_div = FMF_DIV20;
         3'd2:    fmf_div = FMF_DIV15;
         3'd3:    fmf_div = FMF_DIV12;
         default: fmf_div = FMF_DIV10;
      endcase
   endfunction : fmf_div

   logic [31:0] ctrl, next_ctrl, luncfg, next_luncfg, pass, next_pass;
   logic [31:0] result, next_result;
   logic        unlocked, next_unlocked;
   logic [31:0] next_prdata;
   logic        next_pready, next_pslverr;
   fmf_state_e  state, next_state;
   logic [9:0]  lblk, next_lblk, oldp, next_oldp, newp, next_newp;
   logic [9:0]  free_head, next_free_head, bad_cnt, next_bad_cnt;
   logic [9:0]  ram_addr, ram_wdata, ram_rdata;
   logic        ram_we;
   logic [1:0]  wait_cnt, next_wait_cnt;
   logic        wp_eff;
   logic [10:0] used_size;
   logic [4:0]  rcnt, next_rcnt, wcnt, next_wcnt;
   logic        next_rstb, next_wstb;
   logic [7:0]  fhold, next_fhold, uhold, next_uhold;
   logic        wr_ok, rd_ok, wr_cmd, scnt, next_scnt;
   logic [3:0]  cmd;
   logic [1:0]  lun;

   assign wp_eff = write_protect | ~wp_driven;
   assign wr_ok  = psel & penable & pwrite & pready;
   assign rd_ok  = psel & penable & ~pwrite & pready;
   assign wr_cmd = wr_ok & (paddr == FMF_CMD_OFS);
   assign cmd    = pwdata[3:0];
   assign lun    = pwdata[5:4];

   always_comb begin
      unique case (ctrl[FMF_CTRL_RED_LSB +: 2])
         2'd1:    used_size = FMF_USED_90;
         2'd2:    used_size = FMF_USED_50;
         default: used_size = FMF_USED_FULL;
      endcase
   end

   fmf_map_ram u_map (
      .pclk  (pclk),
      .we    (ram_we),
      .addr  (ram_addr),
      .wdata (ram_wdata),
      .rdata (ram_rdata)
   );

   // Map: entries [0,used) used, then free ring, bad at top
   always_comb begin
      next_state     = state;
      next_lblk      = lblk;
      next_oldp      = oldp;
      next_newp      = newp;
      next_free_head = free_head;
      next_bad_cnt   = bad_cnt;
      next_wait_cnt  = wait_cnt;
      next_result    = result;
      next_unlocked  = unlocked;
      next_scnt      = scnt;
      ram_we         = 1'b0;
      ram_addr       = lblk;
      ram_wdata      = newp;
      unique case (state)
         FMF_IDLE: begin
            if (wr_cmd) begin
               next_lblk = pwdata[17:8];
               if (lun == 2'd3 || (lun == 2'd2 &&
                   !(luncfg[FMF_LUN_PRIV_BIT] && luncfg[FMF_LUN_ADD_BIT]))
                   || (lun == 2'd1 && !(luncfg[FMF_LUN_PRIV_BIT] ||
                   luncfg[FMF_LUN_ADD_BIT]))) begin
                  next_result = {30'h0, FMF_ST_NOLUN};
               end else if (cmd == FMF_CMD_UNLOCK) begin
                  next_unlocked = (pwdata[31:16] == pass[15:0]);
                  next_result = {30'h0, next_unlocked ? FMF_ST_OK
                                                     : FMF_ST_LOCK};
               end else if (cmd == FMF_CMD_LOCK) begin
                  next_unlocked = 1'b0;
                  next_result   = {30'h0, FMF_ST_OK};
               end else if (lun == 2'd1 && luncfg[FMF_LUN_PRIV_BIT]
                            && !unlocked) begin
                  next_result = {30'h0, FMF_ST_LOCK};
               end else if (wp_eff && (cmd == FMF_CMD_WRITE ||
                            cmd == FMF_CMD_ERASE)) begin
                  next_result = {30'h0, FMF_ST_WPROT};
               end else if (cmd == FMF_CMD_WRITE &&
                            {1'b0, pwdata[17:8]} < used_size) begin
                  next_result = {30'h0, FMF_ST_OK};
                  next_state  = FMF_PICK;
                  next_wait_cnt = 2'd0;
               end else if (cmd == FMF_CMD_LATE) begin
                  next_state = FMF_LATE;
                  next_wait_cnt = 2'd0;
               end else begin
                  next_result = {30'h0, FMF_ST_OK};
               end
            end
         end
         FMF_PICK: begin
            ram_addr      = (wait_cnt == 2'd0) ? lblk : free_head;
            next_wait_cnt = wait_cnt + 2'd1;
            if (wait_cnt == 2'd1) next_oldp = ram_rdata;
            if (wait_cnt == 2'd2) begin
               next_newp  = ram_rdata;
               next_state = FMF_COPY;
            end
         end
         // Two read strobes copy, then two write strobes program
         FMF_COPY: begin
            next_scnt = scnt ^ (rcnt == 5'd0);
            if (scnt && rcnt == 5'd0) next_state = FMF_WRDATA;
         end
         FMF_WRDATA: begin
            next_scnt = scnt ^ (wcnt == 5'd0);
            if (scnt && wcnt == 5'd0) next_state = FMF_ERASE;
         end
         FMF_ERASE:  next_state = FMF_UPD_USED;
         FMF_UPD_USED: begin
            ram_we     = 1'b1;
            ram_addr   = lblk;
            ram_wdata  = newp;
            next_state = FMF_UPD_FREE;
         end
         FMF_UPD_FREE: begin
            ram_we    = 1'b1;
            ram_addr  = free_head;
            ram_wdata = oldp;
            next_free_head = (free_head + 10'd1 >= 10'(FMF_ZONE_BLOCKS - 1)
                - bad_cnt) ? used_size[9:0] : free_head + 10'd1;
            next_result = {22'h0, newp};
            next_state  = FMF_IDLE;
         end
         FMF_LATE: begin
            ram_addr      = (wait_cnt == 2'd0) ? lblk : free_head;
            next_wait_cnt = wait_cnt + 2'd1;
            if (wait_cnt == 2'd1) next_oldp = ram_rdata;
            if (wait_cnt == 2'd2) begin
               next_newp    = ram_rdata;
               next_bad_cnt = bad_cnt + 10'd1;
               next_state   = FMF_UPD_USED;
            end
         end
      endcase
   end

   // Register bus; map init walks identity at reset is assumed external
   always_comb begin
      next_ctrl    = ctrl;
      next_luncfg  = luncfg;
      next_pass    = pass;
      next_prdata  = prdata;
      next_pready  = psel & ~pready & (state == FMF_IDLE);
      next_pslverr = 1'b0;
      if (wr_ok) begin
         unique case (paddr)
            FMF_CTRL_OFS:   next_ctrl   = pwdata;
            FMF_LUNCFG_OFS: next_luncfg = pwdata;
            FMF_PASS_OFS:   next_pass   = pwdata;
            FMF_CMD_OFS:    next_ctrl   = ctrl;
            default:        next_ctrl   = ctrl;
         endcase
      end
      if (next_pready) begin
         next_pslverr = paddr > FMF_SPEED_OFS || paddr[1:0] != 2'b00;
         unique case (paddr)
            FMF_CTRL_OFS:   next_prdata = ctrl;
            FMF_LUNCFG_OFS: next_prdata = {25'h0, luncfg[FMF_LUN_CD2K_BIT],
                              luncfg[FMF_LUN_ATYP_LSB +: 2],
                              luncfg[FMF_LUN_PTYP_LSB +: 2],
                              luncfg[1:0]};
            FMF_STAT_OFS:   next_prdata = {20'h0, bad_cnt[9:0], unlocked,
                                           wp_eff};
            FMF_MAP_OFS:    next_prdata = {21'h0, used_size};
            FMF_RESULT_OFS: next_prdata = result;
            // Bit0 high speed, endpoint numbers, LUN count
            FMF_SPEED_OFS:  next_prdata = {16'h0, 6'h0,
                              2'd1 + 2'(luncfg[0]) + 2'(luncfg[1]),
                              4'h2, 3'h0, usb_high_speed};
            default:        next_prdata = 32'h0000_0000;
         endcase
         // Type and block size answer for an optical public drive (LUN 0 type only)
         if (paddr == FMF_LUNCFG_OFS && luncfg[FMF_LUN_PTYP_LSB +: 2] ==
             2'(FMF_OPTICAL) && luncfg[FMF_LUN_CD2K_BIT])
            next_prdata[31] = 1'b1;
      end
      if (next_luncfg[FMF_LUN_PTYP_LSB +: 2] == 2'd3)
         next_luncfg[FMF_LUN_PTYP_LSB +: 2] = 2'(FMF_REMOVABLE);
   end

   // Strobe dividers and indicators
   always_comb begin
      next_rcnt = (rcnt == 5'd0) ? fmf_div(ctrl[FMF_CTRL_RDIV_LSB +: 3])
                 - 5'd1 : rcnt - 5'd1;
      next_wcnt = (wcnt == 5'd0) ? fmf_div(ctrl[FMF_CTRL_WDIV_LSB +: 3])
                 - 5'd1 : wcnt - 5'd1;
      next_rstb = state == FMF_COPY && rcnt == 5'd0;
      next_wstb = state == FMF_WRDATA && wcnt == 5'd0;
      next_fhold = (state != FMF_IDLE) ? FMF_LED_HOLD :
                   (fhold == 8'h00 ? 8'h00 : fhold - 8'h01);
      next_uhold = usb_activity ? FMF_LED_HOLD :
                   (uhold == 8'h00 ? 8'h00 : uhold - 8'h01);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl      <= FMF_CTRL_RST;
         luncfg    <= FMF_LUNCFG_RST;
         pass      <= FMF_PASS_RST;
         result    <= 32'h0000_0000;
         unlocked  <= 1'b0;
         prdata    <= 32'h0000_0000;
         pready    <= 1'b0;
         pslverr   <= 1'b0;
         state     <= FMF_IDLE;
         lblk      <= 10'h000;
         oldp      <= 10'h000;
         newp      <= 10'h000;
         free_head <= FMF_USED_FULL[9:0];
         bad_cnt   <= 10'h000;
         wait_cnt  <= 2'd0;
         scnt      <= 1'b0;
         rcnt      <= 5'd0;
         wcnt      <= 5'd0;
         flash_read_strobe  <= 1'b0;
         flash_write_strobe <= 1'b0;
         flash_busy         <= 1'b0;
         fhold     <= 8'h00;
         uhold     <= 8'h00;
         flash_activity_indicator <= 1'b0;
         usb_activity_indicator   <= 1'b0;
      end else begin
         ctrl      <= next_ctrl;
         luncfg    <= next_luncfg;
         pass      <= next_pass;
         result    <= next_result;
         unlocked  <= next_unlocked;
         prdata    <= next_prdata;
         pready    <= next_pready;
         pslverr   <= next_pslverr;
         state     <= next_state;
         lblk      <= next_lblk;
         oldp      <= next_oldp;
         newp      <= next_newp;
         free_head <= next_free_head;
         bad_cnt   <= next_bad_cnt;
         wait_cnt  <= next_wait_cnt;
         scnt      <= next_scnt;
         rcnt      <= next_rcnt;
         wcnt      <= next_wcnt;
         flash_read_strobe  <= next_rstb;
         flash_write_strobe <= next_wstb;
         flash_busy         <= next_state != FMF_IDLE;
         fhold     <= next_fhold;
         uhold     <= next_uhold;
         flash_activity_indicator <= ~ctrl[FMF_CTRL_LED1_BIT] &
                                     (next_fhold != 8'h00);
         usb_activity_indicator   <= (next_uhold != 8'h00) |
            (ctrl[FMF_CTRL_LED1_BIT] & (next_fhold != 8'h00));
      end
   end

   wprot_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_cmd && state == FMF_IDLE && wp_eff && lun == 2'd0 &&
      cmd == FMF_CMD_WRITE |=> state == FMF_IDLE)
      else $error("Write proceeded under protection");
   wprot_status_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_cmd && state == FMF_IDLE && wp_eff && lun == 2'd0 &&
      cmd == FMF_CMD_ERASE |=> result[1:0] == FMF_ST_WPROT)
      else $error("No protect error status");
   write_go_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_cmd && state == FMF_IDLE && !wp_eff && lun == 2'd0 &&
      cmd == FMF_CMD_WRITE && {1'b0, pwdata[17:8]} < used_size
      |=> state == FMF_PICK)
      else $error("Unprotected write refused");
   seq_order_a: assert property (@(posedge pclk) disable iff (!presetn)
      state == FMF_COPY && next_state != FMF_COPY |=> state == FMF_WRDATA)
      else $error("Block write order broken");
   prog_order_a: assert property (@(posedge pclk) disable iff (!presetn)
      state == FMF_WRDATA && next_state != FMF_WRDATA |=>
      state == FMF_ERASE ##1 state == FMF_UPD_USED ##1 state == FMF_UPD_FREE)
      else $error("Erase or map update out of order");
   used_red_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl[FMF_CTRL_RED_LSB +: 2] == 2'd2 |-> used_size == 11'd500)
      else $error("Reduced map size wrong");
   lock_priv_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_cmd && state == FMF_IDLE && cmd == FMF_CMD_LOCK
      && lun == 2'd1 && luncfg[FMF_LUN_PRIV_BIT] |=> !unlocked)
      else $error("Lock did not lock");
   led_swap_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl[FMF_CTRL_LED1_BIT] && $past(ctrl[FMF_CTRL_LED1_BIT])
      |-> !flash_activity_indicator)
      else $error("Indicator one lit while disabled");
   flash_led_a: assert property (@(posedge pclk) disable iff (!presetn)
      state == FMF_COPY && !ctrl[FMF_CTRL_LED1_BIT]
      |=> flash_activity_indicator)
      else $error("Flash indicator idle during access");
   late_bad_a: assert property (@(posedge pclk) disable iff (!presetn)
      state == FMF_LATE && wait_cnt == 2'd2 |=>
      bad_cnt == $past(bad_cnt) + 10'd1 && state == FMF_UPD_USED)
      else $error("Late bad block not counted");
endmodule : fmf_front
`default_nettype wire

// *** test/fmf_flash_model.sv ***
// Behavioural flash array: measures strobe spacing and phase order.
// Assumes one-cycle strobes and a busy level from the front end.
`timescale 1ns/1ps
`default_nettype none
module fmf_flash_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        rd_strobe,
   input  wire logic        wr_strobe,
   input  wire logic        busy,
   output var  logic [15:0] rd_gap,
   output var  logic [15:0] wr_gap,
   output var  logic        order_err
);
   logic [15:0] rcnt;
   logic [15:0] wcnt;
   logic        wseen;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rcnt      <= 16'h0000;
         wcnt      <= 16'h0000;
         rd_gap    <= 16'h0000;
         wr_gap    <= 16'h0000;
         wseen     <= 1'b0;
         order_err <= 1'b0;
      end else begin
         rcnt <= rd_strobe ? 16'h0001 : rcnt + 16'h0001;
         wcnt <= wr_strobe ? 16'h0001 : wcnt + 16'h0001;
         if (rd_strobe) begin
            rd_gap <= rcnt;
         end
         if (wr_strobe) begin
            wr_gap <= wcnt;
         end
         // Copy reads must all come before the data writes
         wseen <= busy & (wseen | wr_strobe);
         if (rd_strobe && wseen) begin
            order_err <= 1'b1;
         end
      end
   end
endmodule : fmf_flash_model
`default_nettype wire

// *** test/fmf_front_tb.sv ***
// Self-checking bench for the front end over APB.
// Assumes fmf_pkg, fmf_front and fmf_flash_model compiled first.
`timescale 1ns/1ps
`default_nettype none
module fmf_front_tb;
   import fmf_pkg::*;
   localparam logic [4:0] DV [5] = '{FMF_DIV30, FMF_DIV20, FMF_DIV15,
                                     FMF_DIV12, FMF_DIV10};
   logic        pclk           = 1'b0;
   logic        presetn        = 1'b0;
   logic        psel           = 1'b0;
   logic        penable        = 1'b0;
   logic        pwrite         = 1'b0;
   logic [11:0] paddr          = 12'h000;
   logic [31:0] pwdata         = 32'h0000_0000;
   logic        write_protect  = 1'b0;
   logic        wp_driven      = 1'b1;
   logic        usb_high_speed = 1'b1;
   logic        usb_activity   = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        frs;
   logic        fws;
   logic        fbusy;
   logic        fai;
   logic        uai;
   logic [15:0] rd_gap;
   logic [15:0] wr_gap;
   logic        order_err;
   logic [31:0] rd;
   logic        err;
   int          error_cnt = 0;
   int          n_tests   = 0;
   int          cyc       = 0;
   always #2.5 pclk = ~pclk;
   fmf_front uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .write_protect(write_protect), .wp_driven(wp_driven),
      .usb_high_speed(usb_high_speed), .usb_activity(usb_activity),
      .flash_read_strobe(frs), .flash_write_strobe(fws),
      .flash_busy(fbusy), .flash_activity_indicator(fai),
      .usb_activity_indicator(uai));
   fmf_flash_model fm (.pclk(pclk), .presetn(presetn), .rd_strobe(frs),
      .wr_strobe(fws), .busy(fbusy), .rd_gap(rd_gap), .wr_gap(wr_gap),
      .order_err(order_err));
   task automatic results;
      $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 90000) begin
         error_cnt++;
         results();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rchk(input string nm, input logic [11:0] a,
                       input logic [31:0] m, e);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, rd & m, e);
   endtask : rchk
   function automatic logic [31:0] cw(input logic [3:0] c,
                                      input logic [1:0] l,
                                      input logic [9:0] b);
      return {14'h0000, b, 2'b00, l, c};
   endfunction : cw
   task automatic cmd(input logic [31:0] w);
      apb(1'b1, FMF_CMD_OFS, w);
      repeat (2) @(posedge pclk);
      while (fbusy !== 1'b0) @(posedge pclk);
   endtask : cmd
   task automatic st(input logic [1:0] e);
      rchk("status", FMF_RESULT_OFS, 32'h0000_0003, 32'(e));
   endtask : st
   task automatic t_regs;
      rchk("ctrl", FMF_CTRL_OFS, 32'hFFFF_FFFF, FMF_CTRL_RST);
      rchk("luncfg", FMF_LUNCFG_OFS, 32'hFFFF_FFFF, FMF_LUNCFG_RST);
      rchk("pass", FMF_PASS_OFS, 32'hFFFF_FFFF, FMF_PASS_RST);
      apb(1'b0, 12'h020, 32'h0000_0000);
      chk("slverr", 32'(err), 32'h0000_0001);
      rchk("speed", FMF_SPEED_OFS, 32'h0000_03F1, 32'h0000_0121);
      usb_high_speed <= 1'b0;
      rchk("speed", FMF_SPEED_OFS, 32'h0000_0001, 32'h0000_0000);
      rchk("map", FMF_MAP_OFS, 32'h0000_07FF, 32'(FMF_USED_FULL));
      apb(1'b1, FMF_CTRL_OFS, 32'h0000_0100);
      rchk("map", FMF_MAP_OFS, 32'h0000_07FF, 32'(FMF_USED_90));
      apb(1'b1, FMF_CTRL_OFS, 32'h0000_0200);
      rchk("map", FMF_MAP_OFS, 32'h0000_07FF, 32'(FMF_USED_50));
      apb(1'b1, FMF_CTRL_OFS, 32'h0000_0000);
   endtask : t_regs
   task automatic t_lun;
      apb(1'b1, FMF_LUNCFG_OFS, 32'h0000_0002);
      rchk("luns", FMF_SPEED_OFS, 32'h0000_0300, 32'h0000_0200);
      cmd(cw(FMF_CMD_READ, 2'd1, 10'd0));
      st(FMF_ST_OK);
      cmd(cw(FMF_CMD_READ, 2'd2, 10'd0));
      st(FMF_ST_NOLUN);
      apb(1'b1, FMF_LUNCFG_OFS, 32'h0000_0003);
      rchk("luns", FMF_SPEED_OFS, 32'h0000_0300, 32'h0000_0300);
      cmd(cw(FMF_CMD_READ, 2'd2, 10'd0));
      st(FMF_ST_OK);
      cmd(cw(FMF_CMD_READ, 2'd3, 10'd0));
      st(FMF_ST_NOLUN);
      cmd(cw(FMF_CMD_READ, 2'd1, 10'd0));
      st(FMF_ST_LOCK);
      apb(1'b1, FMF_PASS_OFS, 32'h0000_A5C3);
      cmd({16'h5A3C, 12'h000, FMF_CMD_UNLOCK});
      rchk("unlocked", FMF_STAT_OFS, 32'h0000_0002, 32'h0000_0000);
      cmd({16'hA5C3, 12'h000, FMF_CMD_UNLOCK});
      rchk("unlocked", FMF_STAT_OFS, 32'h0000_0002, 32'h0000_0002);
      cmd(cw(FMF_CMD_READ, 2'd1, 10'd0));
      st(FMF_ST_OK);
      cmd(cw(FMF_CMD_LOCK, 2'd1, 10'd0));
      cmd(cw(FMF_CMD_READ, 2'd1, 10'd0));
      st(FMF_ST_LOCK);
   endtask : t_lun
   task automatic t_wp;
      write_protect <= 1'b1;
      rchk("protect", FMF_STAT_OFS, 32'h0000_0001, 32'h0000_0001);
      cmd(cw(FMF_CMD_WRITE, 2'd0, 10'd5));
      st(FMF_ST_WPROT);
      cmd(cw(FMF_CMD_ERASE, 2'd0, 10'd5));
      st(FMF_ST_WPROT);
      write_protect <= 1'b0;
      wp_driven     <= 1'b0;
      cmd(cw(FMF_CMD_WRITE, 2'd0, 10'd5));
      st(FMF_ST_WPROT);
      wp_driven <= 1'b1;
      rchk("protect", FMF_STAT_OFS, 32'h0000_0001, 32'h0000_0000);
      cmd(cw(FMF_CMD_LATE, 2'd0, 10'd3));
      rchk("bad_cnt", FMF_STAT_OFS, 32'h0000_0FFC, 32'h0000_0004);
   endtask : t_wp
   task automatic t_rate;
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, FMF_CTRL_OFS, 32'((4 - i) << 4 | i));
         cmd(cw(FMF_CMD_WRITE, 2'd0, 10'(i)));
         chk("rd_gap", 32'(rd_gap), 32'(DV[i]));
         chk("wr_gap", 32'(wr_gap), 32'(DV[4 - i]));
         chk("order", 32'(order_err), 32'h0000_0000);
      end
   endtask : t_rate
   task automatic t_led;
      repeat (300) @(posedge pclk);
      usb_activity <= 1'b1;
      @(posedge pclk);
      usb_activity <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("usb_ind", 32'(uai), 32'h0000_0001);
      chk("fl_ind", 32'(fai), 32'h0000_0000);
      repeat (300) @(posedge pclk);
      cmd(cw(FMF_CMD_WRITE, 2'd0, 10'd7));
      chk("fl_ind", 32'(fai), 32'h0000_0001);
      chk("usb_ind", 32'(uai), 32'h0000_0000);
      repeat (300) @(posedge pclk);
      apb(1'b1, FMF_CTRL_OFS, 32'h0000_0400);
      cmd(cw(FMF_CMD_WRITE, 2'd0, 10'd7));
      chk("usb_ind", 32'(uai), 32'h0000_0001);
      chk("fl_ind", 32'(fai), 32'h0000_0000);
   endtask : t_led
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_lun();
      t_wp();
      t_rate();
      t_led();
      results();
   end
endmodule : fmf_front_tb
`default_nettype wire
